//--- inc/cmsc_pkg.sv
package cmsc_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_MODE = 8'h08;
  localparam logic [7:0] ADR_CARD = 8'h0C;
  localparam logic [7:0] ADR_TXD = 8'h10;
  localparam logic [7:0] ADR_RXD = 8'h14;
  localparam logic [7:0] ADR_IST = 8'h18;
  localparam logic [7:0] ADR_IMSK = 8'h1C;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [2:0] IRQ_RST = 3'h0;
  localparam logic FLAG_RST_TX_BUF_EMPTY = 1'b1;
  localparam logic FLAG_RST_OTHER = 1'b0;

  // Status flag bit positions; flags occupy bits ST_LO..ST_HI
  localparam int ST_TX_BUF_EMPTY = 7;
  localparam int ST_RX_BUF_FULL = 6;
  localparam int ST_OVERRUN_FLAG = 5;
  localparam int ST_FER = 4;
  localparam int ST_PER = 3;
  localparam int ST_LO = 3;
  localparam int ST_HI = 7;

  // Card mode select bit position
  localparam int CARD_SEL_BIT = 0;

  // Sticky event bits
  localparam int EV_TX = 0;
  localparam int EV_RX = 1;
  localparam int EV_ERR = 2;
  localparam int EV_W = 3;

  // Frame layout: start, 8 data, even parity, stop
  localparam logic [3:0] TX_FRAME_END = 4'hB;
  localparam logic [3:0] RX_PAR_IDX = 4'h8;
  localparam logic [3:0] RX_STOP_IDX = 4'h9;

  // Clock select codes
  localparam logic [1:0] CKS_OFF = 2'h0;
  localparam logic [1:0] CKS_HIGH = 2'h2;

  typedef struct packed {
    logic tx_empty_irq_en;
    logic rx_irq_en;
    logic tx_on;
    logic rx_on;
    logic addr_wake_irq_en;
    logic tx_done_irq_en;
    logic clk_sel_hi;
    logic clk_sel_lo;
  } cmsc_ctrl_t;

  typedef struct packed {
    logic sync_mode;
    logic rsvd6;
    logic timing_mode_bit;
    logic [1:0] rsvd4_3;
    logic addr_wake_format;
    logic [1:0] rsvd1_0;
  } cmsc_mode_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SHIFT = 2'b10
  } cmsc_tx_st_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_RECV = 2'b10
  } cmsc_rx_st_t;

endpackage

//--- hw/cmsc_top.sv
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module cmsc_top
  import cmsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic link_clk_i,
  input wire logic rxd_i,
  output logic txd_o,
  output logic sck_o,
  output logic sck_oe_n_o,
  output logic tx_empty_irq_o,
  output logic rx_full_irq_o,
  output logic rx_error_irq_o,
  output logic irq_o
);

  cmsc_ctrl_t ctrl;
  cmsc_mode_t mode;
  logic card_mode_sel;
  logic [7:0] tx_buffer_reg;
  logic [7:0] tx_shift_reg;
  logic [7:0] rx_shift;
  logic [7:0] rx_buffer;
  logic rx_par;
  logic [ST_HI:ST_LO] flag;
  logic [ST_HI:ST_LO] seen_one;
  logic [EV_W-1:0] irq_stat;
  logic [EV_W-1:0] irq_mask;
  cmsc_tx_st_t tx_st;
  cmsc_rx_st_t rx_st;
  logic [3:0] tx_cnt;
  logic [3:0] rx_cnt;
  logic lclk_s1;
  logic lclk_s2;
  logic lclk_prev;
  logic rxd_s1;
  logic rxd_s2;

  // Bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  wire bus_rd = bus_req & ~wb_we_i;
  wire wr_ctrl = bus_wr & (wb_adr_i == ADR_CTRL);
  wire wr_stat = bus_wr & (wb_adr_i == ADR_STAT);
  wire rd_stat = bus_rd & (wb_adr_i == ADR_STAT);
  wire wr_mode = bus_wr & (wb_adr_i == ADR_MODE);
  wire wr_card = bus_wr & (wb_adr_i == ADR_CARD);
  wire wr_txd = bus_wr & (wb_adr_i == ADR_TXD);
  wire wr_ist = bus_wr & (wb_adr_i == ADR_IST);
  wire wr_imsk = bus_wr & (wb_adr_i == ADR_IMSK);
  wire [7:0] wdat = wb_dat_i[7:0];

  // Status byte as read; low bits read zero
  wire [7:0] stat_byte = {flag, 3'h0};

  // Read data selection; unmapped offsets read zero
  wire [7:0] rd_byte =
    (wb_adr_i == ADR_CTRL) ? ctrl :
    (wb_adr_i == ADR_STAT) ? stat_byte :
    (wb_adr_i == ADR_MODE) ? mode :
    (wb_adr_i == ADR_CARD) ? {7'h00, card_mode_sel} :
    (wb_adr_i == ADR_TXD) ? tx_buffer_reg :
    (wb_adr_i == ADR_RXD) ? rx_buffer :
    (wb_adr_i == ADR_IST) ? {5'h00, irq_stat} :
    (wb_adr_i == ADR_IMSK) ? {5'h00, irq_mask} : 8'h00;

  // Link clock edge, taken after the synchroniser
  wire lclk_rise = lclk_s2 & ~lclk_prev;

  // Address wake acts in async mode with its enable and format bits only
  wire addr_wake_act = ctrl.addr_wake_irq_en & ~mode.sync_mode
                     & mode.addr_wake_format;

  // Transmit hand-over from buffer to shifter
  wire tx_load = ctrl.tx_on & (tx_st == TX_IDLE) & ~flag[ST_TX_BUF_EMPTY];
  wire [10:0] tx_frame = {1'b1, ^tx_shift_reg, tx_shift_reg, 1'b0};

  // Receive completion and its checks
  wire rx_done = ctrl.rx_on & (rx_st == RX_RECV) & lclk_rise
               & (rx_cnt == RX_STOP_IDX);
  wire rx_take = rx_done & ~addr_wake_act;
  wire rx_fer = rx_take & ~rxd_s2;
  wire rx_per = rx_take & (rx_par != ^rx_shift);
  wire rx_overrun_flag = rx_take & flag[ST_RX_BUF_FULL];
  wire rx_good = rx_take & ~rx_fer & ~rx_per & ~rx_overrun_flag;

  // Hardware set terms per status flag
  wire [ST_HI:ST_LO] flag_set = {tx_load | ~ctrl.tx_on, rx_good, rx_overrun_flag,
                                 rx_fer, rx_per};

  // Sticky events for the summary interrupt
  wire [EV_W-1:0] ev = {rx_fer | rx_per | rx_overrun_flag, rx_good, tx_load};

  // Clock pin: released, fixed or clock, chosen live from the select field and the mode timing bit
  wire [1:0] cks = {ctrl.clk_sel_hi, ctrl.clk_sel_lo};
  wire sck_drive = mode.timing_mode_bit | (cks == 2'h1);
  wire sck_fixed = mode.timing_mode_bit & ~ctrl.clk_sel_lo;
  wire sck_level = sck_fixed ? (cks == CKS_HIGH) : lclk_s2;

  // Link clock synchroniser and edge history; resets to the idle low level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lclk_s1 <= 1'b0;
      lclk_s2 <= 1'b0;
      lclk_prev <= 1'b0;
    end else if (ce_i) begin
      lclk_s1 <= link_clk_i;
      lclk_s2 <= lclk_s1;
      lclk_prev <= lclk_s2;
    end
  end

  // Receive line synchroniser; resets to the idle high level, no false start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
    end else if (ce_i) begin
      rxd_s1 <= rxd_i;
      rxd_s2 <= rxd_s1;
    end
  end

  // Read data is zero outside a read answer
  wire [31:0] next_dat = bus_rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;

  // Bus slave: one-cycle registered answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= bus_req;
      wb_dat_o <= next_dat;
    end
  end

  // Software-owned registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RST;
      mode <= MODE_RST;
      card_mode_sel <= 1'b0;
      tx_buffer_reg <= 8'h00;
      irq_mask <= IRQ_RST;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        ctrl <= wdat;
      end
      if (wr_mode) begin
        mode <= wdat;
      end
      if (wr_card) begin
        card_mode_sel <= wdat[CARD_SEL_BIT];
      end
      if (wr_txd) begin
        tx_buffer_reg <= wdat;
      end
      if (wr_imsk) begin
        irq_mask <= wdat[EV_W-1:0];
      end
    end
  end

  // Status flags: set wins; a zero clears only after a read as one
  genvar gi;
  generate
    for (gi = ST_LO; gi <= ST_HI; gi++) begin : g_flag
      wire clr = wr_stat & ~wdat[gi] & seen_one[gi];
      localparam logic RST_V = (gi == ST_TX_BUF_EMPTY) ? FLAG_RST_TX_BUF_EMPTY : FLAG_RST_OTHER;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          flag[gi] <= RST_V;
          seen_one[gi] <= 1'b0;
        end else if (ce_i) begin
          if (flag_set[gi]) begin
            flag[gi] <= 1'b1;
          end else if (clr) begin
            flag[gi] <= 1'b0;
          end
          if (wr_stat | ~flag[gi]) begin
            seen_one[gi] <= 1'b0;
          end else if (rd_stat) begin
            seen_one[gi] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // Write-one-to-clear mask and next sticky value; a new event wins
  wire [EV_W-1:0] ist_clr = wr_ist ? wdat[EV_W-1:0] : 3'h0;
  wire [EV_W-1:0] next_irq_stat = ev | (irq_stat & ~ist_clr);

  // Sticky interrupt status, write one to clear, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= IRQ_RST;
    end else if (ce_i) begin
      irq_stat <= next_irq_stat;
    end
  end

  // Transmit engine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_st <= TX_IDLE;
      tx_cnt <= 4'h0;
      tx_shift_reg <= 8'h00;
      txd_o <= 1'b1;
    end else if (ce_i) begin
      case (tx_st)
        TX_IDLE: begin
          txd_o <= 1'b1;
          tx_cnt <= 4'h0;
          if (tx_load) begin
            tx_shift_reg <= tx_buffer_reg;
            tx_st <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (~ctrl.tx_on) begin
            tx_st <= TX_IDLE;
            txd_o <= 1'b1;
          end else if (lclk_rise) begin
            if (tx_cnt == TX_FRAME_END) begin
              tx_st <= TX_IDLE;
              txd_o <= 1'b1;
            end else begin
              txd_o <= tx_frame[tx_cnt];
              tx_cnt <= tx_cnt + 4'h1;
            end
          end
        end
        default: tx_st <= TX_IDLE;
      endcase
    end
  end

  // Receive engine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_st <= RX_IDLE;
      rx_cnt <= 4'h0;
      rx_shift <= 8'h00;
      rx_par <= 1'b0;
      rx_buffer <= 8'h00;
    end else if (ce_i) begin
      case (rx_st)
        RX_IDLE: begin
          rx_cnt <= 4'h0;
          if (ctrl.rx_on & lclk_rise & ~rxd_s2) begin
            rx_st <= RX_RECV;
          end
        end
        RX_RECV: begin
          if (~ctrl.rx_on) begin
            rx_st <= RX_IDLE;
          end else if (lclk_rise) begin
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt < RX_PAR_IDX) begin
              rx_shift <= {rxd_s2, rx_shift[7:1]};
            end else if (rx_cnt == RX_PAR_IDX) begin
              rx_par <= rxd_s2;
            end else begin
              rx_st <= RX_IDLE;
            end
          end
        end
        default: rx_st <= RX_IDLE;
      endcase
      if (rx_good) begin
        rx_buffer <= rx_shift;
      end
    end
  end

  // Next values of the pin and request outputs
  wire next_sck = sck_drive & sck_level;
  wire next_sck_oe_n = ~sck_drive;
  wire next_tx_empty_irq = ctrl.tx_empty_irq_en & flag[ST_TX_BUF_EMPTY];
  wire next_rx_full_irq = ctrl.rx_irq_en & flag[ST_RX_BUF_FULL];
  wire rx_any_err = flag[ST_OVERRUN_FLAG] | flag[ST_FER] | flag[ST_PER];
  wire next_rx_error_irq = ctrl.rx_irq_en & rx_any_err;
  wire next_irq = |(irq_stat & irq_mask);

  // Registered clock pin; released pin shows low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_o <= 1'b0;
      sck_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      sck_o <= next_sck;
      sck_oe_n_o <= next_sck_oe_n;
    end
  end

  // Registered request outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_empty_irq_o <= 1'b0;
      rx_full_irq_o <= 1'b0;
      rx_error_irq_o <= 1'b0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      tx_empty_irq_o <= next_tx_empty_irq;
      rx_full_irq_o <= next_rx_full_irq;
      rx_error_irq_o <= next_rx_error_irq;
      irq_o <= next_irq;
    end
  end

endmodule

//--- dv/cmsc_top_properties.sv
`timescale 1ns/1ps
// Port-level checks; control and mode are shadowed from bus writes
module cmsc_top_properties
  import cmsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic txd_o,
  input wire logic sck_o,
  input wire logic sck_oe_n_o,
  input wire logic tx_empty_irq_o,
  input wire logic rx_full_irq_o,
  input wire logic rx_error_irq_o
);
  logic [7:0] ctl;
  logic [7:0] mde;
  wire wr_ok = wb_ack_o && wb_we_i && wb_sel_i[0];
  wire fix_lo = mde[5] && ctl[1:0] == 2'h0;
  wire fix_hi = mde[5] && ctl[1:0] == 2'h2;
  wire rel = !mde[5] && ctl[1:0] != 2'h1;
  // Shadow copies take the value at the ack edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl <= 8'h00;
      mde <= 8'h00;
    end else if (wr_ok && wb_adr_i == ADR_CTRL) begin
      ctl <= wb_dat_i[7:0];
    end else if (wr_ok && wb_adr_i == ADR_MODE) begin
      mde <= wb_dat_i[7:0];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack did not follow request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  tx_irq_gate_a: assert property (!ctl[7] && !$past(ctl[7]) |-> !tx_empty_irq_o)
    else $error("tx request while disabled");
  rx_irq_gate_a: assert property (!ctl[6] && !$past(ctl[6]) |-> !(rx_full_irq_o || rx_error_irq_o))
    else $error("rx request while disabled");
  tx_idle_a: assert property (!ctl[5] && !$past(ctl[5]) |-> txd_o)
    else $error("transmit while off");
  pin_release_a: assert property (rel && $past(rel) |-> sck_oe_n_o)
    else $error("clock pin not released");
  fixed_low_a: assert property (fix_lo && $past(fix_lo) |-> !sck_oe_n_o && !sck_o)
    else $error("clock pin not low");
  fixed_high_a: assert property (fix_hi && $past(fix_hi) |-> !sck_oe_n_o && sck_o)
    else $error("clock pin not high");
  cover property (tx_empty_irq_o);
  cover property (rx_full_irq_o);
  cover property (rx_error_irq_o);
endmodule
bind cmsc_top cmsc_top_properties u_props (.*);

//--- dv/cmsc_peer.sv
`timescale 1ns/1ps
// Card side: clocks only inside frames, sends rx bits, samples tx bits
module cmsc_peer (
  input wire logic txd_i,
  output logic link_clk_o,
  output logic rxd_o
);
  logic [11:0] tx_seen;
  initial begin
    link_clk_o = 1'h0;
    rxd_o = 1'h1;
    tx_seen = 12'h000;
  end
  // Twelve 400 ns periods; tx is sampled late in each low phase
  task automatic run(input logic [11:0] bits);
    for (int i = 0; i < 12; i++) begin
      rxd_o = bits[i];
      #10 link_clk_o = 1'h1;
      #200 link_clk_o = 1'h0;
      #190 tx_seen[i] = txd_i;
    end
    rxd_o = 1'h1; // Line idles high
  endtask
endmodule

//--- dv/tb_card_mode_serial_ctrl_status.sv
`timescale 1ns/1ps
module tb_card_mode_serial_ctrl_status
  import cmsc_pkg::*;
;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic ce_i = 1'h1;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, link_clk_i, rxd_i, txd_o, sck_o, sck_oe_n_o;
  logic tx_empty_irq_o, rx_full_irq_o, rx_error_irq_o, irq_o;
  int err_count = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'h0000001C;
  logic [31:0] rd;
  logic [7:0] b;
  logic [11:0] q[$];
  always #25 clk_i = ~clk_i;
  cmsc_top DUT (.*);
  cmsc_peer u_peer (.txd_i(txd_o), .link_clk_o(link_clk_i), .rxd_o(rxd_i));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One classic cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    if (wb_ack_o !== 1'h1) begin
      err_count++;
      test_done();
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge clk_i);
  endtask
  // Main sequence: reset, transmit, receive, interrupt, clock pin
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h0, ADR_STAT, 8'h00);
    chk(rd, 32'h80);
    wb(1'h0, 8'h20, 8'h00);
    chk(rd, 32'h0);
    wb(1'h1, ADR_CARD, 8'h01);
    wb(1'h1, ADR_IMSK, 8'h07);
    wb(1'h1, ADR_CTRL, 8'hE0);
    seed = xs(seed);
    b = seed[7:0];
    wb(1'h1, ADR_TXD, b);
    wb(1'h1, ADR_STAT, 8'hF8);
    wb(1'h1, ADR_STAT, 8'h00);
    u_peer.run(12'hFFF);
    chk({20'h0, u_peer.tx_seen}, 32'hFFF);
    chk(tx_empty_irq_o, 32'h1);
    wb(1'h0, ADR_STAT, 8'h00);
    chk(rd, 32'h80);
    wb(1'h1, ADR_STAT, 8'h00);
    q.push_back({2'h3, ^b, b, 1'h0});
    u_peer.run(12'hFFF);
    chk({20'h0, u_peer.tx_seen}, {20'h0, q.pop_front()});
    $display("test transmit done");
    wb(1'h1, ADR_IST, 8'h07);
    wb(1'h1, ADR_CTRL, 8'hF0);
    seed = xs(seed);
    b = seed[7:0];
    u_peer.run({2'h3, ^b, b, 1'h0});
    settle();
    wb(1'h0, ADR_STAT, 8'h00);
    chk(rd, 32'hC0);
    wb(1'h0, ADR_RXD, 8'h00);
    chk(rd, {24'h0, b});
    chk(rx_full_irq_o, 32'h1);
    chk(irq_o, 32'h1);
    wb(1'h1, ADR_IMSK, 8'h00);
    settle();
    chk(irq_o, 32'h0);
    wb(1'h1, ADR_STAT, 8'h80);
    settle();
    chk(rx_full_irq_o, 32'h0);
    u_peer.run({2'h3, ~^b, b, 1'h0});
    settle();
    wb(1'h0, ADR_STAT, 8'h00);
    chk(rd, 32'h88);
    chk(rx_error_irq_o, 32'h1);
    wb(1'h1, ADR_CTRL, 8'hE0);
    wb(1'h1, ADR_STAT, 8'h80);
    u_peer.run({2'h3, ^b, b, 1'h0});
    settle();
    wb(1'h0, ADR_STAT, 8'h00);
    chk(rd, 32'h80);
    chk(rx_error_irq_o, 32'h0);
    $display("test receive done");
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 4; s++) begin
        wb(1'h1, ADR_MODE, (m == 1) ? 8'h20 : 8'h00);
        wb(1'h1, ADR_CTRL, {6'h00, s[1:0]});
        settle();
        chk(sck_oe_n_o, {31'h0, m == 0 && s != 1});
        if (m == 1 && s[0] == 1'h0) chk(sck_o, {31'h0, s[1]});
      end
    end
    wb(1'h0, ADR_STAT, 8'h00);
    chk(rd, 32'h80);
    $display("test clock pin done");
    test_done();
  end
endmodule
